// ==== atatf_regs.sv ====
// Task file register bank of the card: parameter registers, status and interrupt.
// Assumes host strobes are synchronous to sys_clk_i and one cycle wide per access.
// Functional notes
// - Feature register is write-only; its byte feeds the set-features command.
// - Sector count zero means 256 sectors.
// - Sector number is start sector in CHS, block address bits 7:0 in LBA.
// - Cylinder low is cylinder low byte in CHS, block bits 15:8 in LBA.
// - Cylinder high is cylinder high byte in CHS, block bits 23:16 in LBA.
// - Drive/head bit 6 selects CHS at 0, LBA at 1.
// - In LBA, drive/head bits 3:0 give block address bits 27:24.
// - In CHS, drive/head bits 3:0 are the head number, bit 3 MSB.
// - Drive/head bit 4 picks card 0 or 1; card compares with its identity.
// - Status is read-only; other bits valid only when busy is 0.
// - Reading status clears the pending interrupt request.
// - Busy stays 1 while an internal operation runs.
// - Media commands accepted only with ready and seek complete set.
// - After an error, ready changes only after a status read.
// - Write fault bit 5 set on a fault during writing.
// - Seek complete bit 4 set when requested sector is found.
// - Data request bit 3 set when data may move via data register.
// - Corrected bit 2 set when a correctable error was fixed.
// - Index bit 1 always reads 0.
// - Error bit 0 set when previous command ended in error.
`timescale 1ns/100ps
module atatf_regs (
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	input  wire logic [2:0]  reg_addr_i,
	input  wire logic        reg_rd_i,
	input  wire logic        reg_wr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        cmd_media_i,
	input  wire logic        card_identity_setting_i,
	input  wire logic        op_done_i,
	input  wire logic        op_error_i,
	input  wire logic        write_fault_i,
	input  wire logic        sector_found_i,
	input  wire logic        data_ready_i,
	input  wire logic        corrected_i,
	input  wire logic        upd_valid_i,
	input  wire logic [27:0] upd_block_i,
	output logic      [7:0]  reg_rdata_o,
	output logic             interrupt_request_out_o,
	output logic      [7:0]  feature_byte_o,
	output logic      [8:0]  sector_total_o,
	output logic             lba_mode_o,
	output logic      [27:0] block_address_o,
	output logic      [15:0] cylinder_o,
	output logic      [3:0]  head_number_field_o,
	output logic      [7:0]  start_sector_o,
	output logic             card_selected_o,
	output logic             cmd_accept_o,
	output logic             cmd_refused_o
);
	atatf_if st ();

	logic [7:0] feature_select;
	logic [7:0] transfer_sector_count;
	logic [7:0] start_sector_or_block_low;
	logic [7:0] cylinder_low_or_block_mid;
	logic [7:0] cylinder_high_or_block_high;
	logic [7:0] drive_and_head_select;
	logic [7:0] command_status;
	logic       cmd_wr;
	logic       selected;
	logic       accept;

	// Sector count with zero meaning a full 256
	function automatic logic [8:0] sector_total(input logic [7:0] cnt);
		sector_total = (cnt == 8'h00) ? atatf_pkg::FULL_COUNT : {1'b0, cnt};
	endfunction

	atatf_status u_status (
		.sys_clk_i      (sys_clk_i),
		.srst_i         (srst_i),
		.op_done_i      (op_done_i),
		.op_error_i     (op_error_i),
		.write_fault_i  (write_fault_i),
		.sector_found_i (sector_found_i),
		.data_ready_i   (data_ready_i),
		.corrected_i    (corrected_i),
		.st             (st)
	);

	assign selected = (drive_and_head_select[atatf_pkg::DH_DRV] == card_identity_setting_i);
	assign cmd_wr = reg_wr_i && (reg_addr_i == atatf_pkg::ADDR_STATUS) && selected;
	// No new media command while a data phase is still open
	assign accept = !st.busy && !st.dreq && st.drive_ready_flag && st.seek;
	assign st.cmd_start = cmd_wr && cmd_media_i && accept;
	assign st.stat_read = reg_rd_i && (reg_addr_i == atatf_pkg::ADDR_STATUS);

	always_comb begin
		command_status = 8'h00;
		command_status[atatf_pkg::BIT_BUSY]   = st.busy;
		command_status[atatf_pkg::BIT_DRIVE_READY_FLAG]   = st.drive_ready_flag;
		command_status[atatf_pkg::BIT_WFAULT] = st.wfault;
		command_status[atatf_pkg::BIT_SEEK]   = st.seek;
		command_status[atatf_pkg::BIT_DREQ]   = st.dreq;
		command_status[atatf_pkg::BIT_CORRECTED_DATA_FLAG]   = st.corrected_data_flag;
		command_status[atatf_pkg::BIT_INDEX]  = 1'b0;
		command_status[atatf_pkg::BIT_ERROR]  = st.err;
	end

	// Host writes; a command's address update overrides nothing the host writes
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			feature_select              <= atatf_pkg::RST_BYTE;
			transfer_sector_count       <= atatf_pkg::RST_SECCOUNT;
			start_sector_or_block_low   <= atatf_pkg::RST_SECNUM;
			cylinder_low_or_block_mid   <= atatf_pkg::RST_BYTE;
			cylinder_high_or_block_high <= atatf_pkg::RST_BYTE;
			drive_and_head_select       <= atatf_pkg::RST_DRVHEAD;
		end else if (reg_wr_i && !st.busy) begin
			case (reg_addr_i)
				atatf_pkg::ADDR_FEATURE:  feature_select <= reg_wdata_i;
				atatf_pkg::ADDR_SECCOUNT: transfer_sector_count <= reg_wdata_i;
				atatf_pkg::ADDR_SECNUM:   start_sector_or_block_low <= reg_wdata_i;
				atatf_pkg::ADDR_CYL_LOW:  cylinder_low_or_block_mid <= reg_wdata_i;
				atatf_pkg::ADDR_CYL_HIGH: cylinder_high_or_block_high <= reg_wdata_i;
				atatf_pkg::ADDR_DRVHEAD:  begin
					drive_and_head_select <= reg_wdata_i | atatf_pkg::DH_FIXED_ONES;
				end
				default: begin
				end
			endcase
		end else if (upd_valid_i) begin
			start_sector_or_block_low   <= upd_block_i[7:0];
			cylinder_low_or_block_mid   <= upd_block_i[15:8];
			cylinder_high_or_block_high <= upd_block_i[23:16];
			drive_and_head_select[3:0]  <= upd_block_i[27:24];
		end
	end

	// Read data; feature register reads as the error location, here zero
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			reg_rdata_o <= atatf_pkg::UNMAPPED_READ;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				atatf_pkg::ADDR_SECCOUNT: reg_rdata_o <= transfer_sector_count;
				atatf_pkg::ADDR_SECNUM:   reg_rdata_o <= start_sector_or_block_low;
				atatf_pkg::ADDR_CYL_LOW:  reg_rdata_o <= cylinder_low_or_block_mid;
				atatf_pkg::ADDR_CYL_HIGH: reg_rdata_o <= cylinder_high_or_block_high;
				atatf_pkg::ADDR_DRVHEAD:  reg_rdata_o <= drive_and_head_select;
				atatf_pkg::ADDR_STATUS:   reg_rdata_o <= command_status;
				default:                  reg_rdata_o <= atatf_pkg::UNMAPPED_READ;
			endcase
		end
	end

	// Interrupt: set at completion, cleared by status read; set wins
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			interrupt_request_out_o <= 1'b0;
		end else if (st.irq_set) begin
			interrupt_request_out_o <= 1'b1;
		end else if (st.stat_read) begin
			interrupt_request_out_o <= 1'b0;
		end
	end

	// Decoded addressing outputs
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			feature_byte_o      <= atatf_pkg::RST_BYTE;
			sector_total_o      <= atatf_pkg::FULL_COUNT;
			lba_mode_o          <= 1'b0;
			block_address_o     <= 28'h0000000;
			cylinder_o          <= 16'h0000;
			head_number_field_o <= 4'h0;
			start_sector_o      <= atatf_pkg::RST_BYTE;
			card_selected_o     <= 1'b0;
		end else begin
			feature_byte_o      <= feature_select;
			sector_total_o      <= sector_total(transfer_sector_count);
			lba_mode_o          <= drive_and_head_select[atatf_pkg::DH_LBA];
			block_address_o     <= {drive_and_head_select[3:0], cylinder_high_or_block_high,
				cylinder_low_or_block_mid, start_sector_or_block_low};
			cylinder_o          <= {cylinder_high_or_block_high,
				cylinder_low_or_block_mid};
			head_number_field_o <= drive_and_head_select[3:0];
			start_sector_o      <= start_sector_or_block_low;
			card_selected_o     <= selected;
		end
	end

	// Command acceptance pulses
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			cmd_accept_o  <= 1'b0;
			cmd_refused_o <= 1'b0;
		end else begin
			cmd_accept_o  <= st.cmd_start;
			cmd_refused_o <= cmd_wr && cmd_media_i && !accept;
		end
	end

	a_irq_clear: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		st.stat_read && !st.irq_set |=> !interrupt_request_out_o)
		else $error("interrupt not cleared by status read");
	a_refuse_cmd: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		cmd_wr && cmd_media_i && !st.drive_ready_flag |=> cmd_refused_o && !cmd_accept_o)
		else $error("media command accepted without ready");
	a_index_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		st.stat_read |=> !reg_rdata_o[atatf_pkg::BIT_INDEX])
		else $error("index bit read as one");
	a_count_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		transfer_sector_count == 8'h00 |=> sector_total_o == atatf_pkg::FULL_COUNT)
		else $error("zero count not 256");
	a_lba_map: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		##1 block_address_o[27:24] == $past(drive_and_head_select[3:0]))
		else $error("upper block bits wrong");
	a_sel_match: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		reg_wr_i && (reg_addr_i == atatf_pkg::ADDR_STATUS) && cmd_media_i && !selected
		|=> !cmd_accept_o && !cmd_refused_o)
		else $error("command taken by unselected card");
endmodule

// ==== atatf_pkg.sv ====
// Package for the task file register bank: offsets, field positions, reset values.
// Assumes a byte-wide host register port with a 3-bit register address.
package atatf_pkg;
	localparam logic [2:0] ADDR_DATA      = 3'h0;
	localparam logic [2:0] ADDR_FEATURE   = 3'h1;
	localparam logic [2:0] ADDR_SECCOUNT  = 3'h2;
	localparam logic [2:0] ADDR_SECNUM    = 3'h3;
	localparam logic [2:0] ADDR_CYL_LOW   = 3'h4;
	localparam logic [2:0] ADDR_CYL_HIGH  = 3'h5;
	localparam logic [2:0] ADDR_DRVHEAD   = 3'h6;
	localparam logic [2:0] ADDR_STATUS    = 3'h7;

	localparam int BIT_BUSY      = 7;
	localparam int BIT_DRIVE_READY_FLAG      = 6;
	localparam int BIT_WFAULT    = 5;
	localparam int BIT_SEEK      = 4;
	localparam int BIT_DREQ      = 3;
	localparam int BIT_CORRECTED_DATA_FLAG      = 2;
	localparam int BIT_INDEX     = 1;
	localparam int BIT_ERROR     = 0;

	localparam int DH_LBA        = 6;
	localparam int DH_DRV        = 4;

	localparam logic [7:0] DH_FIXED_ONES  = 8'ha0;
	localparam logic [7:0] RST_BYTE       = 8'h00;
	localparam logic [7:0] RST_SECCOUNT   = 8'h01;
	localparam logic [7:0] RST_SECNUM     = 8'h01;
	localparam logic [7:0] RST_DRVHEAD    = 8'ha0;
	localparam logic [8:0] FULL_COUNT     = 9'h100;
	localparam logic [7:0] UNMAPPED_READ  = 8'h00;

	typedef enum logic [1:0] {
		ATATF_IDLE = 2'b00,
		ATATF_BUSY = 2'b01,
		ATATF_XFER = 2'b10
	} atatf_state_t;
endpackage

// ==== atatf_if.sv ====
// Interface between register bank and status engine.
// Assumes one clock domain shared by both modules.
`timescale 1ns/100ps
interface atatf_if;
	logic        busy;
	logic        drive_ready_flag;
	logic        wfault;
	logic        seek;
	logic        dreq;
	logic        corrected_data_flag;
	logic        err;
	logic        stat_read;
	logic        cmd_start;
	logic        irq_set;

	modport engine (
		output busy, drive_ready_flag, wfault, seek, dreq, corrected_data_flag, err, irq_set,
		input  stat_read, cmd_start
	);
	modport bank (
		input  busy, drive_ready_flag, wfault, seek, dreq, corrected_data_flag, err, irq_set,
		output stat_read, cmd_start
	);
endinterface

// ==== atatf_status.sv ====
// Status engine: keeps busy, ready and result flags of the running operation.
// Assumes event inputs are synchronous one-cycle pulses from the media controller.
`timescale 1ns/100ps
module atatf_status (
	input  wire logic sys_clk_i,
	input  wire logic srst_i,
	input  wire logic op_done_i,
	input  wire logic op_error_i,
	input  wire logic write_fault_i,
	input  wire logic sector_found_i,
	input  wire logic data_ready_i,
	input  wire logic corrected_i,
	atatf_if.engine   st
);
	atatf_pkg::atatf_state_t state;

	// Busy while an operation runs until data ready, then data request until completion
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state <= atatf_pkg::ATATF_IDLE;
		end else begin
			case (state)
				atatf_pkg::ATATF_IDLE: begin
					if (st.cmd_start) begin
						state <= atatf_pkg::ATATF_BUSY;
					end
				end
				atatf_pkg::ATATF_BUSY: begin
					if (op_done_i || op_error_i) begin
						state <= atatf_pkg::ATATF_IDLE;
					end else if (data_ready_i) begin
						state <= atatf_pkg::ATATF_XFER;
					end
				end
				atatf_pkg::ATATF_XFER: begin
					if (op_done_i || op_error_i) begin
						state <= atatf_pkg::ATATF_IDLE;
					end
				end
				default: begin
					state <= atatf_pkg::ATATF_IDLE;
				end
			endcase
		end
	end

	assign st.busy = (state == atatf_pkg::ATATF_BUSY);
	assign st.dreq = (state == atatf_pkg::ATATF_XFER);
	assign st.irq_set = (state != atatf_pkg::ATATF_IDLE) && (op_done_i || op_error_i);

	// Result flags, cleared when a new command starts; set wins over clear
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			st.wfault <= 1'b0;
			st.seek   <= 1'b1;
			st.corrected_data_flag   <= 1'b0;
			st.err    <= 1'b0;
		end else begin
			if (write_fault_i) begin
				st.wfault <= 1'b1;
			end else if (st.cmd_start) begin
				st.wfault <= 1'b0;
			end
			if (sector_found_i) begin
				st.seek <= 1'b1;
			end else if (st.cmd_start) begin
				st.seek <= 1'b0;
			end
			if (corrected_i) begin
				st.corrected_data_flag <= 1'b1;
			end else if (st.cmd_start) begin
				st.corrected_data_flag <= 1'b0;
			end
			if (op_error_i) begin
				st.err <= 1'b1;
			end else if (st.cmd_start) begin
				st.err <= 1'b0;
			end
		end
	end

	// Ready drops on error and returns only after the host reads status
	logic drive_ready_flag_hold;
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			st.drive_ready_flag   <= 1'b1;
			drive_ready_flag_hold <= 1'b0;
		end else if (op_error_i) begin
			st.drive_ready_flag   <= 1'b0;
			drive_ready_flag_hold <= 1'b1;
		end else if (drive_ready_flag_hold && st.stat_read) begin
			st.drive_ready_flag   <= 1'b1;
			drive_ready_flag_hold <= 1'b0;
		end
	end

	a_ready_held: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		drive_ready_flag_hold && !st.stat_read |=> !st.drive_ready_flag)
		else $error("ready changed before status read");
	a_busy_ends: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		st.busy && op_done_i |=> !st.busy)
		else $error("busy not cleared at completion");
	a_error_flag: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		op_error_i |=> st.err)
		else $error("error flag not set");
	a_fault_flag: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		write_fault_i |=> st.wfault)
		else $error("write fault flag not set");
	a_corrected_data_flag_flag: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		corrected_i |=> st.corrected_data_flag)
		else $error("corrected flag not set");
endmodule

// ==== atatf_host_model.sv ====
// Host side of the register port: byte reads and writes, one at a time.
// Assumes the bench calls the tasks in sequence from one process.
`timescale 1ns/100ps
module atatf_host_model (
	input  wire logic       sys_clk_i,
	input  wire logic [7:0] reg_rdata_i,
	output logic      [2:0] reg_addr_o,
	output logic            reg_rd_o,
	output logic            reg_wr_o,
	output logic      [7:0] reg_wdata_o,
	output logic            cmd_media_o
);
	initial begin
		reg_addr_o  = 3'h0;
		reg_rd_o    = 1'b0;
		reg_wr_o    = 1'b0;
		reg_wdata_o = 8'h00;
		cmd_media_o = 1'b0;
	end

	// Request held up to the taking edge; released data shows its inverse
	task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic m);
		@(posedge sys_clk_i);
		reg_addr_o  <= a;
		reg_wdata_o <= d;
		reg_wr_o    <= 1'b1;
		cmd_media_o <= m;
		@(posedge sys_clk_i);
		reg_wr_o    <= 1'b0;
		cmd_media_o <= 1'b0;
		reg_wdata_o <= ~d;
		#1;
	endtask

	// Read data taken 1 ns after the taking edge
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_o <= a;
		reg_rd_o   <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_o   <= 1'b0;
		#1;
		d = reg_rdata_i;
	endtask
endmodule

// ==== ata_task_file_registers_tb_top.sv ====
// Testbench for the task file register bank: host accesses and media events.
// Assumes the host model drives the register port; events come from here.
`timescale 1ns/100ps
module ata_task_file_registers_tb_top;
	logic        sys_clk_i;
	logic        srst_i;
	logic        ident;
	logic [5:0]  ev;
	logic [2:0]  addr;
	logic        rd_s;
	logic        wr_s;
	logic        media;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        irq;
	logic [7:0]  feat;
	logic [8:0]  total;
	logic        lba;
	logic [27:0] blk;
	logic [15:0] cyl;
	logic [3:0]  head;
	logic [7:0]  ssec;
	logic        csel;
	logic        acc;
	logic        refd;
	logic [7:0]  s;
	logic        upd;
	logic [27:0] ublk;
	int          n_mismatch;
	int          comparisons;
	int          cycles;

	atatf_host_model HOST (.sys_clk_i(sys_clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
		.reg_rd_o(rd_s), .reg_wr_o(wr_s), .reg_wdata_o(wdata), .cmd_media_o(media));

	atatf_regs DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(addr),
		.reg_rd_i(rd_s), .reg_wr_i(wr_s), .reg_wdata_i(wdata), .cmd_media_i(media),
		.card_identity_setting_i(ident), .op_done_i(ev[0]), .op_error_i(ev[1]),
		.write_fault_i(ev[2]), .sector_found_i(ev[3]), .data_ready_i(ev[4]),
		.corrected_i(ev[5]), .upd_valid_i(upd), .upd_block_i(ublk),
		.reg_rdata_o(rdata), .interrupt_request_out_o(irq), .feature_byte_o(feat),
		.sector_total_o(total), .lba_mode_o(lba), .block_address_o(blk),
		.cylinder_o(cyl), .head_number_field_o(head), .start_sector_o(ssec),
		.card_selected_o(csel), .cmd_accept_o(acc), .cmd_refused_o(refd));

	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	task automatic chk(input string nm, input logic [27:0] seen, input logic [27:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	// Event pulses: 0 done, 1 error, 2 write fault, 3 found, 4 data ready, 5 corrected
	task automatic pulse(input int i);
		@(posedge sys_clk_i);
		ev[i] <= 1'b1;
		@(posedge sys_clk_i);
		ev[i] <= 1'b0;
	endtask

	task automatic print_verdict;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	initial begin
		srst_i = 1'b1;
		ident = 1'b0;
		ev = 6'h00;
		upd = 1'b0;
		ublk = 28'h0000000;
		n_mismatch = 0;
		comparisons = 0;
		cycles = 0;
		repeat (16) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		// Reset values and fixed bits
		HOST.rd(3'h7, s);
		chk("status", s, 8'h50);
		HOST.rd(3'h2, s);
		chk("count", s, 8'h01);
		HOST.rd(3'h6, s);
		chk("drvhead", s, 8'ha0);
		// Parameter bytes and address assembly
		HOST.wr(3'h1, 8'h3c, 1'b0);
		HOST.wr(3'h2, 8'h00, 1'b0);
		HOST.wr(3'h3, 8'h12, 1'b0);
		HOST.wr(3'h4, 8'h34, 1'b0);
		HOST.wr(3'h5, 8'h56, 1'b0);
		HOST.wr(3'h6, 8'h47, 1'b0);
		cyc(2);
		chk("feature", feat, 8'h3c);
		chk("total", total, 9'h100);
		chk("lba", lba, 1'b1);
		chk("block", blk, 28'h7563412);
		chk("selected", csel, 1'b1);
		HOST.rd(3'h1, s);
		chk("feature_rd", s, 8'h00);
		HOST.rd(3'h6, s);
		chk("drvhead_rd", s, 8'he7);
		HOST.wr(3'h6, 8'ha5, 1'b0);
		cyc(2);
		chk("lba", lba, 1'b0);
		chk("head", head, 4'h5);
		chk("cyl", cyl, 16'h5634);
		chk("start", ssec, 8'h12);
		// Accepted command, busy, write ignored, result flags, interrupt
		HOST.wr(3'h7, 8'h20, 1'b1);
		chk("accept", acc, 1'b1);
		HOST.wr(3'h2, 8'h99, 1'b0);
		HOST.rd(3'h7, s);
		chk("busy", s[7], 1'b1);
		pulse(3);
		pulse(5);
		pulse(0);
		cyc(2);
		chk("irq", irq, 1'b1);
		// Host trusts other bits only with busy clear
		HOST.rd(3'h7, s);
		chk("status", s, 8'h54);
		cyc(1);
		chk("irq_clr", irq, 1'b0);
		HOST.rd(3'h2, s);
		chk("count_kept", s, 8'h00);
		// Write fault and error, refusal until status read
		HOST.wr(3'h7, 8'h30, 1'b1);
		chk("accept_wr", acc, 1'b1);
		pulse(3);
		pulse(2);
		pulse(1);
		cyc(2);
		HOST.wr(3'h7, 8'h30, 1'b1);
		chk("refused", refd, 1'b1);
		HOST.rd(3'h7, s);
		chk("err_busy", s[7], 1'b0);
		chk("err_rdy", s[6], 1'b0);
		chk("wfault", s[5], 1'b1);
		chk("err", s[0], 1'b1);
		HOST.rd(3'h7, s);
		chk("rdy_back", s[6], 1'b1);
		// Data request phase
		HOST.wr(3'h7, 8'h20, 1'b1);
		chk("accept_rd", acc, 1'b1);
		pulse(4);
		cyc(2);
		HOST.rd(3'h7, s);
		chk("dreq", {s[7], s[3]}, 2'b01);
		pulse(0);
		cyc(2);
		HOST.rd(3'h7, s);
		chk("dreq_off", s[3], 1'b0);
		// Command update of the address bytes, then a non-media command
		@(posedge sys_clk_i);
		upd  <= 1'b1;
		ublk <= 28'h9abcdef;
		@(posedge sys_clk_i);
		upd  <= 1'b0;
		cyc(2);
		chk("blk_upd", blk, 28'h9abcdef);
		HOST.rd(3'h3, s);
		chk("secnum_upd", s, 8'hef);
		HOST.wr(3'h7, 8'hef, 1'b0);
		chk("non_media", {acc, refd}, 2'b00);
		// Card not selected: command neither taken nor refused
		@(posedge sys_clk_i);
		ident <= 1'b1;
		cyc(3);
		chk("unselected", csel, 1'b0);
		HOST.wr(3'h7, 8'h20, 1'b1);
		chk("no_accept", {acc, refd}, 2'b00);
		print_verdict();
	end
endmodule
